// File: common/ddc_pkg.sv
// shared constants and carrier types for the dual dac decay control block
package ddc_pkg;
   localparam int DDC_DATA_W = 8;
   localparam int DDC_MAG_W = 7;
   localparam int DDC_LVL_W = 3;
   localparam int DDC_SYNC_STAGES = 3;
   localparam int DDC_TOP_BIT = 7;
   localparam int DDC_LVL_MSB = 6;
   localparam int DDC_LVL_LSB = 4;
   localparam logic [6:0] DDC_MAG_RST = 7'h00;
   localparam logic [2:0] DDC_LVL_RST = 3'h0;
   localparam logic DDC_DIR_RST = 1'b0;
   localparam logic DDC_DECAY_N_RST = 1'b0;

   typedef struct packed {
      logic [7:0] data;
      logic channel_select;
      logic register_kind_select;
   } ddc_wr_t;

   typedef struct packed {
      logic [6:0] magnitude;
      logic direction;
      logic fast_decay_n;
      logic [2:0] threshold;
   } ddc_chan_t;
endpackage

// File: rtl/ddc_sync.sv
// three-stage synchroniser for asynchronous pin inputs with agree-to-change filter
`timescale 1ns/1ps
module ddc_sync
   import ddc_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a bit moves only once stages two and three agree, masking one-cycle glitches
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               level[i] <= RST_VAL[i];
            end else if (s2_q[i] == s3_q[i]) begin
               level[i] <= s3_q[i];
            end
         end
      end
   endgenerate
endmodule

// File: rtl/ddc_top.sv
// dual channel data/decay-level register file with fast-decay comparator
//
// Contract
// - byte is captured into the selected register on the write strobe rising edge
// - channel_select low picks channel one, high picks channel two
// - register_kind_select low picks data register, high picks decay-level register
// - chip select is active low; while high no register changes
// - data write copies top data bit, uninverted, to that channel's direction output
// - fast-decay output is active low: low fast decay, high slow decay
// - fast decay only if new value below both old value and threshold
// - fast-decay flip-flop updates on data writes only, never on level writes
// - the decay level offers eight selectable thresholds
// - each channel holds a 7-bit magnitude code with 128 levels
// - four registers, two per channel, eight data bits, strobe and chip select
// - high reset input clears all registers; it defaults inactive
// - level register holds data bits six to four, compared with magnitude top bits
// - power-up clears every flip-flop except the chip-select synchroniser bits, which reset high; all outputs start low
`timescale 1ns/1ps
module ddc_top
   import ddc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reset_pin,
   input wire logic [7:0] data_in,
   input wire logic channel_select,
   input wire logic register_kind_select,
   input wire logic chip_select_n,
   input wire logic write_strobe,
   output logic direction_ch1,
   output logic direction_ch2,
   output logic fast_decay_n_ch1,
   output logic fast_decay_n_ch2,
   output logic [6:0] analog_out_ch1,
   output logic [6:0] analog_out_ch2,
   output logic [2:0] decay_threshold_ch1,
   output logic [2:0] decay_threshold_ch2
);
   localparam int SYNC_W = DDC_DATA_W + 4;
   localparam logic [SYNC_W-1:0] SYNC_RST = {{DDC_DATA_W{1'b0}}, 1'b0, 1'b0, 1'b1, 1'b0};

   logic [SYNC_W-1:0] pins_s;
   logic [7:0] data_s;
   logic chan_s;
   logic kind_s;
   logic cs_n_s;
   logic wr_s;
   logic wr_prev_q;
   logic reset_s;
   logic clear;
   logic wr_rise;
   ddc_wr_t wr;
   // one array per field, so each element has exactly one driving process
   logic [DDC_MAG_W-1:0] mag_q [2];
   logic dir_q [2];
   logic fast_n_q [2];
   logic [DDC_LVL_W-1:0] thr_q [2];
   // read-only view of each channel, assembled from the field registers
   ddc_chan_t ch [2];

   // all host pins are asynchronous to clk; chip select resets high so nothing is selected
   ddc_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync_bus (
      .clk(clk),
      .rst_n(rst_n),
      .pin({data_in, channel_select, register_kind_select, chip_select_n, write_strobe}),
      .level(pins_s)
   );

   ddc_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_rst (
      .clk(clk),
      .rst_n(rst_n),
      .pin(reset_pin),
      .level(reset_s)
   );

   assign data_s = pins_s[SYNC_W-1:4];
   assign chan_s = pins_s[3];
   assign kind_s = pins_s[2];
   assign cs_n_s = pins_s[1];
   assign wr_s = pins_s[0];

   // rst_n stands in for power-on reset; reset pin is an extra high-active clear
   assign clear = reset_s;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_prev_q <= 1'b0;
      end else begin
         wr_prev_q <= wr_s;
      end
   end

   // data and select are the synchronised copies sampled alongside the strobe edge,
   // so they must be stable around the rising edge as the host bus timing implies
   assign wr_rise = wr_s && !wr_prev_q && !cs_n_s;
   assign wr.data = data_s;
   assign wr.channel_select = chan_s;
   assign wr.register_kind_select = kind_s;

   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_chan
         logic hit;
         logic hit_data;
         logic hit_lvl;
         logic [6:0] new_mag;
         logic [2:0] new_top;
         logic below_old;
         logic below_lvl;

         // channel index compared as a single bit; only two channels exist
         assign hit = wr_rise && (wr.channel_select == 1'(c));

         // register kind splits the channel hit into data and level writes
         assign hit_data = hit && !wr.register_kind_select;
         assign hit_lvl = hit && wr.register_kind_select;

         // magnitude excludes the sign bit; level field is the top three of those
         assign new_mag = wr.data[DDC_MAG_W-1:0];
         assign new_top = wr.data[DDC_LVL_MSB:DDC_LVL_LSB];

         // both tests are strict: equal values keep slow decay
         assign below_old = new_mag < mag_q[c];
         assign below_lvl = new_top < thr_q[c];

         // magnitude register feeds the converter input directly
         always_ff @(posedge clk) begin
            if (!rst_n || clear) begin
               mag_q[c] <= DDC_MAG_RST;
            end else if (hit_data) begin
               mag_q[c] <= new_mag;
            end
         end

         // sign follows the top data bit of every data write, never inverted
         always_ff @(posedge clk) begin
            if (!rst_n || clear) begin
               dir_q[c] <= DDC_DIR_RST;
            end else if (hit_data) begin
               dir_q[c] <= wr.data[DDC_TOP_BIT];
            end
         end

         // comparison uses the old magnitude, so it must sample before the data reg updates
         always_ff @(posedge clk) begin
            if (!rst_n || clear) begin
               fast_n_q[c] <= DDC_DECAY_N_RST;
            end else if (hit_data) begin
               fast_n_q[c] <= !(below_old && below_lvl);
            end
         end

         // three bits give eight thresholds; a level write leaves the decay flag alone
         always_ff @(posedge clk) begin
            if (!rst_n || clear) begin
               thr_q[c] <= DDC_LVL_RST;
            end else if (hit_lvl) begin
               thr_q[c] <= new_top;
            end
         end

         // gather the fields so the output mapping below reads per channel
         assign ch[c].magnitude = mag_q[c];
         assign ch[c].direction = dir_q[c];
         assign ch[c].fast_decay_n = fast_n_q[c];
         assign ch[c].threshold = thr_q[c];
      end
   endgenerate

   // every output is a flip-flop value; no logic sits between register and pin
   assign direction_ch1 = ch[0].direction;
   assign direction_ch2 = ch[1].direction;
   assign fast_decay_n_ch1 = ch[0].fast_decay_n;
   assign fast_decay_n_ch2 = ch[1].fast_decay_n;
   assign analog_out_ch1 = ch[0].magnitude;
   assign analog_out_ch2 = ch[1].magnitude;
   assign decay_threshold_ch1 = ch[0].threshold;
   assign decay_threshold_ch2 = ch[1].threshold;
endmodule

// File: tb/ddc_top_assertions.sv
// port assertions for the decay control block
`timescale 1ns/1ps
module ddc_top_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reset_pin,
   input wire logic [7:0] data_in,
   input wire logic channel_select,
   input wire logic register_kind_select,
   input wire logic chip_select_n,
   input wire logic direction_ch1,
   input wire logic fast_decay_n_ch1,
   input wire logic fast_decay_n_ch2,
   input wire logic [6:0] analog_out_ch1,
   input wire logic [6:0] analog_out_ch2,
   input wire logic [2:0] decay_threshold_ch1
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rst; $rose(rst_n) |-> !(analog_out_ch1 || fast_decay_n_ch2); endproperty
   a_rst: assert property (p_rst) else $error("not clear after reset");
   property p_pin; reset_pin [*8] |-> !(analog_out_ch2 || decay_threshold_ch1); endproperty
   a_pin: assert property (p_pin) else $error("reset pin did not clear");
   // pins are held well past the sync lag, so three edges back is inside the write window
   property p_cap1; $changed(analog_out_ch1) && analog_out_ch1 != 0 |-> !$past(chip_select_n, 3)
      && !$past(channel_select, 3) && analog_out_ch1 == $past(data_in[6:0], 3); endproperty
   a_cap1: assert property (p_cap1) else $error("bad ch1 capture");
   property p_cap2; $changed(analog_out_ch2) && analog_out_ch2 != 0
      |-> $past(channel_select, 3) && !$past(register_kind_select, 3); endproperty
   a_cap2: assert property (p_cap2) else $error("bad ch2 capture");
   property p_dir; $changed(analog_out_ch1) && analog_out_ch1 != 0
      |-> direction_ch1 == $past(data_in[7], 3); endproperty
   a_dir: assert property (p_dir) else $error("bad direction");
   property p_thr; $changed(decay_threshold_ch1) && decay_threshold_ch1 != 0
      |-> $past(register_kind_select, 3) && decay_threshold_ch1 == $past(data_in[6:4], 3);
   endproperty
   a_thr: assert property (p_thr) else $error("bad threshold capture");
   property p_rose; $rose(fast_decay_n_ch2) |-> !$past(register_kind_select, 3); endproperty
   a_rose: assert property (p_rose) else $error("decay flag moved on level write");
   property p_decay; $changed(analog_out_ch1) && analog_out_ch1 != 0 |-> fast_decay_n_ch1 ==
      !(analog_out_ch1 < $past(analog_out_ch1) && analog_out_ch1[6:4] < decay_threshold_ch1);
   endproperty
   a_decay: assert property (p_decay) else $error("bad decay flag");
endmodule
bind ddc_top ddc_top_assertions ddc_top_assertions_inst (.*);

// File: tb/ddc_host.sv
// bus host model driving the parallel write port
`timescale 1ns/1ps
module ddc_host (
   input wire logic clk,
   output logic [7:0] data_in = 8'h00,
   output logic channel_select = 1'b0,
   output logic register_kind_select = 1'b0,
   output logic chip_select_n = 1'b1,
   output logic write_strobe = 1'b0
);
   task automatic put(input logic [2:0] sel, input logic [7:0] d);
      @(negedge clk);
      {chip_select_n, channel_select, register_kind_select, data_in} = {sel, d};
      repeat (5) @(negedge clk);
      write_strobe = 1'b1;
      repeat (10) @(negedge clk);
      write_strobe = 1'b0;
      repeat (5) @(negedge clk);
      chip_select_n = 1'b1;
      // a released bus never keeps the last byte
      data_in = ~d;
   endtask
endmodule

// File: tb/tb.sv
// self-checking bench for the decay control block
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reset_pin = 1'b0;
   logic [7:0] d;
   logic cs, ks, csn, ws, dir1, dir2, fd1, fd2;
   logic [6:0] mag1, mag2;
   logic [2:0] thr1, thr2;
   int mismatches = 0;
   int n_tests = 0;
   always #25 clk = ~clk;
   ddc_host ddc_host_inst (.clk(clk), .data_in(d), .channel_select(cs),
      .register_kind_select(ks), .chip_select_n(csn), .write_strobe(ws));
   ddc_top ddc_top_inst (.clk(clk), .rst_n(rst_n), .reset_pin(reset_pin), .data_in(d),
      .channel_select(cs), .register_kind_select(ks), .chip_select_n(csn),
      .write_strobe(ws), .direction_ch1(dir1), .direction_ch2(dir2),
      .fast_decay_n_ch1(fd1), .fast_decay_n_ch2(fd2), .analog_out_ch1(mag1),
      .analog_out_ch2(mag2), .decay_threshold_ch1(thr1), .decay_threshold_ch2(thr2));
   // expected words are {direction, fast_decay_n, magnitude, threshold}
   task automatic step(input logic [2:0] sel, input logic [7:0] b, input logic [23:0] e);
      if (sel != 3'h7) ddc_host_inst.put(sel, b);
      n_tests++;
      if ({dir1, fd1, mag1, thr1, dir2, fd2, mag2, thr2} !== e) begin
         mismatches++;
         $display("[ERR] channels expected %h seen %h", e,
            {dir1, fd1, mag1, thr1, dir2, fd2, mag2, thr2});
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      step(3'h7, 8'h00, 24'h000000);
      step(3'b001, 8'h50, 24'h005000);
      step(3'b000, 8'hC0, 24'hE05000);
      step(3'b000, 8'h3F, 24'h1FD000);
      step(3'b001, 8'h30, 24'h1FB000);
      step(3'b000, 8'h3E, 24'h5F3000);
      step(3'b100, 8'h11, 24'h5F3000);
      step(3'b010, 8'h85, 24'h5F3C28);
      step(3'b011, 8'h70, 24'h5F3C2F);
      step(3'b010, 8'h04, 24'h5F3027);
      reset_pin = 1'b1;
      repeat (10) @(negedge clk);
      step(3'h7, 8'h00, 24'h000000);
      reset_pin = 1'b0;
      results();
   end
endmodule
